/* File: gahc_consts.svh */
// Constants for the global adapter control block
`ifndef GAHC_CONSTS_SVH
`define GAHC_CONSTS_SVH

// ==========================================
// Register offsets (byte addresses)
`define GAHC_OFS_CTRL        8'h04
`define GAHC_OFS_IRQ_STAT    8'h20
`define GAHC_OFS_IRQ_EN      8'h24
`define GAHC_OFS_IRQ_CLR     8'h28
`define GAHC_OFS_MSG_CFG     8'h2C

// ==========================================
// Control register field positions
`define GAHC_BIT_NIE         31
`define GAHC_BIT_SVF         2
`define GAHC_BIT_GIE         1
`define GAHC_BIT_ARST        0

// ==========================================
// Message configuration field positions
`define GAHC_BIT_MSIE        0
`define GAHC_LSB_MMC         4
`define GAHC_LSB_MME         8

// ==========================================
// Event status bit positions
`define GAHC_EV_RST_DONE     0
`define GAHC_EV_SVF_SET      1
`define GAHC_EV_SVF_CLR      2
`define GAHC_EV_WIDTH        3

// ==========================================
// Reset values and timing
`define GAHC_RST_ZERO        32'h0000_0000
`define GAHC_RST_EV          3'h0
`define GAHC_RST_MSG         3'h0
`define GAHC_RST_TIME_NS     64
`define GAHC_RST_CYCLES      ((`GAHC_RST_TIME_NS + 7) / 8)
`define GAHC_CNT_W           4

`endif

/* File: gahc_pkg.sv */
// Types shared by the global adapter control block
package gahc_pkg;

	// ==========================================
	// Adapter reset sequencer states
	typedef enum logic [1:0] {
		GAHC_IDLE,
		GAHC_RESETTING,
		GAHC_DONE
	} gahc_rst_e;

	// ==========================================
	// Sequencer state
	typedef struct packed {
		gahc_rst_e       state;
		logic [3:0]      cnt;
		logic            busy;
		logic            done;
	} gahc_seq_s;

endpackage

/* File: gahc_rst_seq.sv */
// Adapter reset sequencer: holds the internal reset for a fixed time, and the link reset too when staggered spin-up is off
`timescale 1ns/100ps
`include "gahc_consts.svh"

module gahc_rst_seq (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Control
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	gahc_pkg::gahc_seq_s seq_ff;
	gahc_pkg::gahc_seq_s nxt_seq;

	// ==========================================
	// Next state
	always_comb begin
		nxt_seq = seq_ff;
		nxt_seq.done = 1'b0;
		unique case (seq_ff.state)
			gahc_pkg::GAHC_IDLE: begin
				if (start) begin
					nxt_seq.state = gahc_pkg::GAHC_RESETTING;
					nxt_seq.cnt   = 4'(`GAHC_RST_CYCLES - 1);
					nxt_seq.busy  = 1'b1;
				end
			end
			gahc_pkg::GAHC_RESETTING: begin
				// Fixed length keeps every port reset long enough to be seen
				if (seq_ff.cnt == 4'h0) begin
					nxt_seq.state = gahc_pkg::GAHC_DONE;
				end else begin
					nxt_seq.cnt = seq_ff.cnt - 4'h1;
				end
			end
			gahc_pkg::GAHC_DONE: begin
				nxt_seq.state = gahc_pkg::GAHC_IDLE;
				nxt_seq.busy  = 1'b0;
				nxt_seq.done  = 1'b1;
			end
		endcase
	end

	// ==========================================
	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_ff <= '{gahc_pkg::GAHC_IDLE, 4'h0, 1'b0, 1'b0};
		end else begin
			seq_ff <= nxt_seq;
		end
	end

	assign busy = seq_ff.busy;
	assign done = seq_ff.done;

endmodule

/* File: gahc_top.sv */
// Global adapter control register bank with interrupt gating and adapter reset
`timescale 1ns/100ps
`include "gahc_consts.svh"

module gahc_top (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Configuration straps and per-port inputs
	input  wire logic        native_only_capability,
	input  wire logic        staggered_spinup,
	input  wire logic [31:0] global_interrupt_status,
	// Adapter controls toward the rest of the chip
	output logic             native_interface_enable,
	output logic             fis_post_allow,
	output logic             cmd_issue_allow,
	output logic             port_irq_allow,
	output logic             msg_single_vector,
	output logic             msg_vector_any,
	output logic             adapter_reset_active,
	output logic             port_comreset,
	output logic             legacy_present,
	output logic             irq
);

	// ==========================================
	// State record
	typedef struct packed {
		logic [1:0]  nos_sync;
		logic        nos;
		logic [1:0]  stg_sync;
		logic        nie;
		logic        gie;
		logic        arst;
		logic        svf;
		logic        msie;
		logic [2:0]  mmc;
		logic [2:0]  mme;
		logic [2:0]  ev_stat;
		logic [2:0]  ev_en;
		logic [1:0]  isr_sync;
		logic        isr_any;
		logic [31:0] rdata;
		logic        fis_ok;
		logic        cmd_ok;
		logic        irq_ok;
		logic        single;
		logic        vec_any;
		logic        rst_act;
		logic        comreset;
		logic        legacy;
		logic        irq;
	} gahc_state_s;

	gahc_state_s st_ff;
	gahc_state_s nxt_st;

	logic        seq_start;
	logic        seq_busy;
	logic        seq_done;
	logic        svf_cond;
	logic        ctrl_wr;
	logic [31:0] ctrl_rd;
	logic [2:0]  ev_set;

	// ==========================================
	// Adapter reset sequencer
	gahc_rst_seq gahc_rst_seq_inst (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.start   (seq_start),
		.busy    (seq_busy),
		.done    (seq_done)
	);

	// Request an adapter reset only on a one written to the reset bit
	assign ctrl_wr   = reg_wr && (reg_addr == `GAHC_OFS_CTRL);
	assign seq_start = ctrl_wr && reg_wdata[`GAHC_BIT_ARST] && !st_ff.arst;

	// Fallback conditions: enabled, several asked, several granted, granted differs
	assign svf_cond = st_ff.msie && (st_ff.mmc != 3'h0) && (st_ff.mme != 3'h0)
		&& (st_ff.mme != st_ff.mmc);

	// Control register readback, reserved bits forced to zero
	always_comb begin
		ctrl_rd = `GAHC_RST_ZERO;
		ctrl_rd[`GAHC_BIT_NIE]  = st_ff.nie;
		ctrl_rd[`GAHC_BIT_SVF]  = st_ff.svf;
		ctrl_rd[`GAHC_BIT_GIE]  = st_ff.gie;
		ctrl_rd[`GAHC_BIT_ARST] = st_ff.arst;
	end

	// Event sources feeding the sticky status bits
	always_comb begin
		ev_set = `GAHC_RST_EV;
		ev_set[`GAHC_EV_RST_DONE] = seq_done;
		ev_set[`GAHC_EV_SVF_SET]  = svf_cond && !st_ff.svf;
		ev_set[`GAHC_EV_SVF_CLR]  = !svf_cond && st_ff.svf;
	end

	// ==========================================
	// Next state
	always_comb begin
		nxt_st = st_ff;

		// Strap passes two flops, then is held as the capability
		nxt_st.nos_sync = {st_ff.nos_sync[0], native_only_capability};
		nxt_st.nos      = st_ff.nos_sync[1];
		nxt_st.legacy   = !st_ff.nos_sync[1];
		// Spin-up strap is a pin as well, so it gets its own two flops
		nxt_st.stg_sync = {st_ff.stg_sync[0], staggered_spinup};
		nxt_st.isr_sync = {st_ff.isr_sync[0], |global_interrupt_status};
		nxt_st.isr_any  = st_ff.isr_sync[1];

		// Control register writes; reserved bits are simply not stored
		if (ctrl_wr) begin
			nxt_st.gie = reg_wdata[`GAHC_BIT_GIE];
			if (!st_ff.nos) begin
				nxt_st.nie = reg_wdata[`GAHC_BIT_NIE];
			end
			if (reg_wdata[`GAHC_BIT_ARST]) begin
				nxt_st.arst = 1'b1;
			end
		end
		// Native-only parts hold the enable at one
		if (st_ff.nos) begin
			nxt_st.nie = 1'b1;
		end

		// Self-clear after the sequencer finishes; a later write of one restarts it
		if (seq_done && !seq_start) begin
			nxt_st.arst = 1'b0;
		end
		// The internal reset returns interrupt enable to its idle value
		if (seq_busy) begin
			nxt_st.gie = 1'b0;
		end

		// Message configuration, normally mirrored from the capability block
		if (reg_wr && (reg_addr == `GAHC_OFS_MSG_CFG)) begin
			nxt_st.msie = reg_wdata[`GAHC_BIT_MSIE];
			nxt_st.mmc  = reg_wdata[`GAHC_LSB_MMC +: 3];
			nxt_st.mme  = reg_wdata[`GAHC_LSB_MME +: 3];
		end

		// Fallback flag follows its conditions; zero granted forces it clear
		nxt_st.svf = svf_cond;
		if (st_ff.msie && (st_ff.mme == 3'h0)) begin
			nxt_st.svf = 1'b0;
		end

		// Sticky events: a set in the same cycle as a clear wins
		if (reg_wr && (reg_addr == `GAHC_OFS_IRQ_CLR)) begin
			nxt_st.ev_stat = st_ff.ev_stat & ~reg_wdata[`GAHC_EV_WIDTH-1:0];
		end
		nxt_st.ev_stat = nxt_st.ev_stat | ev_set;
		if (reg_wr && (reg_addr == `GAHC_OFS_IRQ_EN)) begin
			nxt_st.ev_en = reg_wdata[`GAHC_EV_WIDTH-1:0];
		end

		// Read data for the cycle after the strobe; unmapped reads return zero
		nxt_st.rdata = `GAHC_RST_ZERO;
		if (reg_rd) begin
			unique case (reg_addr)
				`GAHC_OFS_CTRL:     nxt_st.rdata = ctrl_rd;
				`GAHC_OFS_IRQ_STAT: nxt_st.rdata = {29'h0, st_ff.ev_stat};
				`GAHC_OFS_IRQ_EN:   nxt_st.rdata = {29'h0, st_ff.ev_en};
				`GAHC_OFS_MSG_CFG:  nxt_st.rdata = {20'h0, 1'b0, st_ff.mme, 1'b0,
					st_ff.mmc, 3'h0, st_ff.msie};
				default:            nxt_st.rdata = `GAHC_RST_ZERO;
			endcase
		end

		// Native paths are blocked while disabled or while the adapter resets
		nxt_st.fis_ok  = nxt_st.nie && !seq_busy && !seq_start;
		nxt_st.cmd_ok  = nxt_st.nie && !seq_busy && !seq_start;
		nxt_st.irq_ok  = nxt_st.gie;
		// All messages fold onto vector zero in fallback mode
		nxt_st.single  = nxt_st.svf;
		nxt_st.vec_any = nxt_st.gie && st_ff.isr_any;
		nxt_st.rst_act = seq_busy || seq_start;
		nxt_st.comreset = (seq_busy || seq_start) && !st_ff.stg_sync[1];
		nxt_st.irq     = |(nxt_st.ev_stat & nxt_st.ev_en);
	end

	// ==========================================
	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{legacy: 1'b1, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from flops
	assign reg_rdata               = st_ff.rdata;
	assign native_interface_enable = st_ff.nie;
	assign fis_post_allow          = st_ff.fis_ok;
	assign cmd_issue_allow         = st_ff.cmd_ok;
	assign port_irq_allow          = st_ff.irq_ok;
	assign msg_single_vector       = st_ff.single;
	assign msg_vector_any          = st_ff.vec_any;
	assign adapter_reset_active    = st_ff.rst_act;
	assign port_comreset           = st_ff.comreset;
	assign legacy_present          = st_ff.legacy;
	assign irq                     = st_ff.irq;

endmodule

/* File: gahc_top_props.sv */
// Property checker for the global adapter control block
`timescale 1ns/100ps

module gahc_props (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Straps and controls
	input wire logic        native_only_capability,
	input wire logic        staggered_spinup,
	input wire logic        native_interface_enable,
	input wire logic        fis_post_allow,
	input wire logic        cmd_issue_allow,
	input wire logic        port_irq_allow,
	input wire logic        msg_vector_any,
	input wire logic        adapter_reset_active,
	input wire logic        port_comreset,
	input wire logic        legacy_present
);
	// ==========================================
	// One domain, so clock and disable are given once
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Two low cycles asked, though the registered gate and the enable change on the same edge
	property p_post_gate;
		!native_interface_enable && !$past(native_interface_enable)
			|-> !fis_post_allow && !cmd_issue_allow;
	endproperty
	a_post_gate: assert property (p_post_gate) else $error("posting while native off");
	property p_rsv_zero;
		$past(reg_rd) && $past(reg_addr) == 8'h04 |-> reg_rdata[30:3] == 28'h0;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero) else $error("reserved control bits set");
	property p_gie_gate;
		!port_irq_allow && !$past(port_irq_allow) |-> !msg_vector_any;
	endproperty
	a_gie_gate: assert property (p_gie_gate) else $error("interrupt passed gate");
	// Reset sequence lasts about ten cycles; eight are held for certain
	property p_rst_hold;
		$rose(adapter_reset_active) |-> adapter_reset_active [*8];
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("adapter reset too short");
	property p_rst_end;
		$rose(adapter_reset_active) |-> ##[8:14] !adapter_reset_active;
	endproperty
	a_rst_end: assert property (p_rst_end) else $error("adapter reset never ends");
	// Spin-up strap passes a synchroniser, so the gate sees it three cycles late
	property p_comreset;
		$rose(adapter_reset_active) && !$past(staggered_spinup, 3) |-> port_comreset;
	endproperty
	a_comreset: assert property (p_comreset) else $error("link reset missing");
	property p_stagger_quiet;
		staggered_spinup [*3] |-> !port_comreset;
	endproperty
	a_stagger_quiet: assert property (p_stagger_quiet) else $error("link reset with spin-up");
	// Strap passes a synchroniser, so it must be steady a while first
	property p_legacy;
		native_only_capability [*8] |-> !legacy_present;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy shown when native only");
endmodule

bind gahc_top gahc_props gahc_props_inst (
	.ref_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .native_only_capability,
	.staggered_spinup, .native_interface_enable, .fis_post_allow, .cmd_issue_allow,
	.port_irq_allow, .msg_vector_any, .adapter_reset_active, .port_comreset, .legacy_present
);

/* File: tb_gahc_top.sv */
// Self-checking bench for the global adapter control block
`timescale 1ns/100ps

module tb_gahc_top;
	// ==========================================
	// Stimulus and observed signals
	logic        ref_clk = 1'h0;
	logic        rst_n = 1'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic        native_only_capability = 1'h0;
	logic        staggered_spinup = 1'h0;
	logic [31:0] global_interrupt_status = 32'h0;
	logic [31:0] reg_rdata;
	logic        native_interface_enable, fis_post_allow, cmd_issue_allow, port_irq_allow;
	logic        msg_single_vector, msg_vector_any, adapter_reset_active, port_comreset;
	logic        legacy_present, irq, e;
	int          errors = 0;
	int          total_checks = 0;
	int          i;
	// Message config cases: bit 0 enable, 6:4 asked, 10:8 granted
	logic [10:0] cs [5] = '{11'h131, 11'h130, 11'h331, 11'h031, 11'h201};

	gahc_top gahc_top_inst (
		.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.native_only_capability, .staggered_spinup, .global_interrupt_status,
		.native_interface_enable, .fis_post_allow, .cmd_issue_allow, .port_irq_allow,
		.msg_single_vector, .msg_vector_any, .adapter_reset_active, .port_comreset,
		.legacy_present, .irq
	);

	// ==========================================
	// Clock, compare and bus tasks
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Strobes last one cycle; data is taken the cycle after a read
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1;
		chk(reg_rdata & m, x);
	endtask
	task automatic reboot;
		@(posedge ref_clk) rst_n <= 1'h0;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'h1;
	endtask
	// Hang guard
	initial begin
		#400000;
		$display("mismatch at %0t: timeout", $time);
		errors++;
		complete_run();
	end

	// ==========================================
	// Main sequence
	task automatic run_tests;
		reboot();
		rd(8'h04, 32'hFFFFFFFF, 32'h0);
		wr(8'h04, 32'hFFFFFFFE);
		rd(8'h04, 32'hFFFFFFFF, 32'h80000002);
		chb(fis_post_allow, 1'h1);
		chb(port_irq_allow, 1'h1);
		rd(8'h10, 32'hFFFFFFFF, 32'h0);
		@(posedge ref_clk) global_interrupt_status <= 32'h00000010;
		wr(8'h04, 32'h80000002);
		cyc(4);
		chb(msg_vector_any, 1'h1);
		wr(8'h04, 32'h80000000);
		cyc(3);
		chb(msg_vector_any, 1'h0);
		chb(port_irq_allow, 1'h0);
		$display("test fields done");
		foreach (cs[k]) begin
			wr(8'h2C, {21'h0, cs[k]});
			cyc(3);
			e = cs[k][0] && cs[k][6:4] != 3'h0 && cs[k][10:8] != 3'h0 && cs[k][10:8] != cs[k][6:4];
			rd(8'h04, 32'h4, {29'h0, e, 2'h0});
			chb(msg_single_vector, e);
		end
		@(posedge ref_clk) global_interrupt_status <= 32'h0;
		$display("test fallback done");
		// Sticky events: raise, mask, clear
		rd(8'h20, 32'h6, 32'h6);
		wr(8'h24, 32'h4);
		cyc(2);
		chb(irq, 1'h1);
		wr(8'h24, 32'h0);
		cyc(2);
		chb(irq, 1'h0);
		wr(8'h24, 32'h7);
		wr(8'h28, 32'h6);
		rd(8'h20, 32'h6, 32'h0);
		rd(8'h28, 32'hFFFFFFFF, 32'h0);
		chb(irq, 1'h0);
		$display("test events done");
		for (int s = 0; s < 2; s++) begin
			@(posedge ref_clk) staggered_spinup <= s[0];
			cyc(3);
			wr(8'h04, 32'h80000001);
			rd(8'h04, 32'h1, 32'h1);
			chb(adapter_reset_active, 1'h1);
			chb(fis_post_allow, 1'h0);
			chb(port_comreset, !s[0]);
			wr(8'h04, 32'h80000000);
			rd(8'h04, 32'h1, 32'h1);
			for (i = 0; i < 40 && adapter_reset_active !== 1'h0; i++) cyc(1);
			if (i == 40) begin
				$display("mismatch at %0t: reset hang", $time);
				errors++;
				return;
			end
			rd(8'h04, 32'h1, 32'h0);
			rd(8'h20, 32'h1, 32'h1);
			cyc(2);
			chb(irq, 1'h1);
			wr(8'h28, 32'h1);
		end
		$display("test adapter reset done");
		wr(8'h04, 32'h0);
		cyc(3);
		chb(cmd_issue_allow, 1'h0);
		chb(legacy_present, 1'h1);
		@(posedge ref_clk) native_only_capability <= 1'h1;
		reboot();
		cyc(8);
		rd(8'h04, 32'h80000000, 32'h80000000);
		wr(8'h04, 32'h0);
		rd(8'h04, 32'h80000000, 32'h80000000);
		chb(native_interface_enable, 1'h1);
		chb(legacy_present, 1'h0);
		$display("test native only done");
	endtask
	initial begin
		run_tests();
		complete_run();
	end
endmodule
